// [hdl/svc_cmd_regs.svh]
`ifndef SVC_CMD_REGS_SVH
`define SVC_CMD_REGS_SVH
`define CH_CR        8'h0D
`define CH_LF        8'h0A
`define CH_COMMA     8'h2C
`define CH_COLON     8'h3A
`define CH_C         8'h43
`define CH_R         8'h52
`define CH_E         8'h45
`define CH_B         8'h42
`define CH_M         8'h4D
`define CH_W         8'h57
`define CH_ZERO      8'h30
`define CH_NINE      8'h39
`define ERR_NONE     4'h0
`define ERR_UNSUP    4'h1
`define ERR_ARGCNT   4'h2
`define ERR_RANGE    4'h3
`define ERR_ARGLEN   4'h4
`define ERR_PROTECT  4'h5
`define ERR_NOKEY    4'h6
`define ERR_VALUE    4'h7
`define ERR_ACCESS   4'h9
`define IDX_MAX      10'h3E7
`define IDX_PROT_MAX 10'h003
`define IDX_DIG_MAX  3'h4
`define ARG_MAX      3'h3
`define VAL_DIG_MAX  3'h6
`define PCT_MAX      17'h003E8
`define BL_FULL      12'hFFF
`define BL_RESET     12'h000
`define HOUR_CYCLES  40'h68C6171400
`define ZERO32       32'h00000000
`define FS_DEFAULT   32'h00000064
`endif

// [hdl/svc_cmd_pkg.sv]
package svc_cmd_pkg;
   typedef enum logic [2:0] {
      RESP_VALUE, RESP_CLEAR_ACK, RESP_BACKLIGHT, RESP_WRITE_ECHO, RESP_ERROR
   } resp_kind_t;
endpackage

// [hdl/uart_service_command_parser.sv]
// Operation
// RQ1 - Count hours; read or clear them
// RQ2 - Clear answers fixed two-character acknowledgement
// RQ3 - Full-scale query returns unscaled rated flow
// RQ4 - Backlight accepts zero to one hundred percent
// RQ5 - Backlight query reports counts and percent
// RQ6 - Table read returns entry zero to 999
// RQ7 - Table write stores and echoes index, value
// RQ8 - Protected entries refused with code five; code does so for entry zero only, entries 1 to 3 need the vendor key
// RQ9 - Unsupported or locked command gives code one
// RQ10 - Wrong argument count gives code two
// RQ11 - Index outside range gives code three
// RQ12 - Wrong argument length gives code four
// RQ13 - Unknown keyword six, bad value seven
// RQ14 - Code eight unused; code nine bad key
// RQ15 - Exactly one answer per command
`timescale 1ns/1ns
`include "svc_cmd_regs.svh"
module uart_service_command_parser #(
   parameter logic [39:0] HOUR_CYCLES = `HOUR_CYCLES
) (
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   input  wire logic                    rx_valid,
   input  wire logic [7:0]              rx_data,
   input  wire logic                    back_door_en,
   input  wire logic                    vendor_access_key,
   input  wire logic [31:0]             full_scale_lpm,
   output logic                         resp_valid,
   output svc_cmd_pkg::resp_kind_t      resp_kind,
   output logic [31:0]                  resp_value,
   output logic [9:0]                   resp_index,
   output logic [16:0]                  resp_pct_x10,
   output logic [3:0]                   resp_error,
   output logic [11:0]                  backlight_counts
);
   import svc_cmd_pkg::*;

   logic                rst_s1_q, rst_s2_q;
   logic [7:0]          cmd0_q, cmd1_q;
   logic [1:0]          cmd_len_q;
   logic [2:0]          argn_q;
   logic [2:0]          dig_q [0:1];
   logic [31:0]         num_q [0:1];
   logic                bad_char_q, arg_alpha_q;
   logic [7:0]          arg_ch_q;
   logic                in_cmd_q;
   logic [31:0]         table_q [0:999];
   logic [39:0]         cyc_q;
   logic [31:0]         hours_q;
   logic                clr_hours;
   logic                wr_en;
   logic [11:0]         bl_q;

   function automatic logic is_digit(input logic [7:0] c);
      return (c >= `CH_ZERO) && (c <= `CH_NINE);
   endfunction

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   wire logic eol  = rx_valid && (rx_data == `CH_CR || rx_data == `CH_LF);
   wire logic sep  = rx_valid && (rx_data == `CH_COMMA || rx_data == `CH_COLON);
   wire logic body = rx_valid && !eol && !sep;

   // Collect command letters, then argument fields split at separators.
   always_ff @(posedge sys_clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         cmd0_q      <= 8'h00;
         cmd1_q      <= 8'h00;
         cmd_len_q   <= 2'h0;
         argn_q      <= 3'h0;
         in_cmd_q    <= 1'b1;
         bad_char_q  <= 1'b0;
         arg_alpha_q <= 1'b0;
         arg_ch_q    <= 8'h00;
         for (int i = 0; i < 2; i++) begin
            dig_q[i] <= 3'h0;
            num_q[i] <= `ZERO32;
         end
      end else if (eol) begin
         cmd_len_q   <= 2'h0;
         argn_q      <= 3'h0;
         in_cmd_q    <= 1'b1;
         bad_char_q  <= 1'b0;
         arg_alpha_q <= 1'b0;
         for (int i = 0; i < 2; i++) begin
            dig_q[i] <= 3'h0;
            num_q[i] <= `ZERO32;
         end
      end else if (sep) begin
         in_cmd_q <= 1'b0;
         if (argn_q != `ARG_MAX)
            argn_q <= argn_q + 3'h1;
      end else if (body) begin
         if (in_cmd_q) begin
            if (cmd_len_q == 2'h0)
               cmd0_q <= rx_data;
            else if (cmd_len_q == 2'h1)
               cmd1_q <= rx_data;
            if (cmd_len_q != 2'h3)
               cmd_len_q <= cmd_len_q + 2'h1;
         end else if (argn_q == 3'h1 || argn_q == 3'h2) begin
            if (argn_q == 3'h1)
               arg_ch_q <= rx_data;
            if (is_digit(rx_data)) begin
               if (dig_q[argn_q[1]] != 3'h7)
                  dig_q[argn_q[1]] <= dig_q[argn_q[1]] + 3'h1;
               num_q[argn_q[1]] <= 32'(num_q[argn_q[1]] * 32'h0000000A
                                      + 32'(rx_data - `CH_ZERO));
            end else if (argn_q == 3'h1) begin
               arg_alpha_q <= 1'b1;
               if (dig_q[0] != 3'h7)
                  dig_q[0] <= dig_q[0] + 3'h1;
            end else begin
               bad_char_q <= 1'b1;
            end
         end
      end
   end

   // Decode a finished line with command letters into exactly one answer.
   logic        ans_d;
   resp_kind_t  kind_d;
   logic [31:0] val_d;
   logic [3:0]  err_d;
   logic [2:0]  nargs;
   logic        two_ch;
   logic [9:0]  idx;
   always_comb begin
      ans_d     = eol && (cmd_len_q != 2'h0); // RQ15
      kind_d    = RESP_ERROR;
      val_d     = `ZERO32;
      err_d     = `ERR_NONE;
      clr_hours = 1'b0;
      wr_en     = 1'b0;
      nargs     = argn_q;
      two_ch    = (cmd_len_q == 2'h2);
      idx       = num_q[0][9:0];
      if (cmd_len_q == 2'h1 && cmd0_q == `CH_C) begin
         if (nargs != 3'h1)
            err_d = `ERR_ARGCNT; // RQ10
         else if (dig_q[0] != 3'h1)
            err_d = `ERR_ARGLEN; // RQ12
         else if (arg_ch_q == `CH_R) begin
            kind_d = RESP_VALUE; // RQ1
            val_d  = hours_q;
         end else if (arg_ch_q == `CH_C) begin
            kind_d    = RESP_CLEAR_ACK; // RQ2
            clr_hours = ans_d; // RQ1
         end else
            err_d = `ERR_NOKEY; // RQ13
      end else if (cmd_len_q == 2'h1 && cmd0_q == `CH_E) begin
         if (nargs != 3'h0)
            err_d = `ERR_ARGCNT; // RQ10
         else begin
            kind_d = RESP_VALUE; // RQ3
            val_d  = full_scale_lpm;
         end
      end else if (cmd_len_q == 2'h1 && cmd0_q == `CH_B) begin
         if (nargs == 3'h0)
            kind_d = RESP_BACKLIGHT; // RQ5
         else if (nargs != 3'h1)
            err_d = `ERR_ARGCNT; // RQ10
         else if (arg_alpha_q || dig_q[0] == 3'h0)
            err_d = `ERR_VALUE; // RQ13
         else if (num_q[0] > 32'(`PCT_MAX / 17'h0000A))
            err_d = `ERR_VALUE; // RQ4
         else begin
            kind_d = RESP_VALUE; // RQ4
            val_d  = num_q[0];
         end
      end else if (two_ch && cmd0_q == `CH_M && (cmd1_q == `CH_R || cmd1_q == `CH_W)) begin
         if (!back_door_en)
            err_d = `ERR_UNSUP; // RQ9
         else if (nargs != ((cmd1_q == `CH_W) ? 3'h2 : 3'h1))
            err_d = `ERR_ARGCNT; // RQ10
         else if (dig_q[0] == 3'h0 || dig_q[0] > `IDX_DIG_MAX ||
                  (cmd1_q == `CH_W && (dig_q[1] == 3'h0 || dig_q[1] > `VAL_DIG_MAX)))
            err_d = `ERR_ARGLEN; // RQ12
         else if (arg_alpha_q || bad_char_q)
            err_d = `ERR_VALUE; // RQ13
         else if (num_q[0] > 32'(`IDX_MAX))
            err_d = `ERR_RANGE; // RQ11
         else if (cmd1_q == `CH_R) begin
            kind_d = RESP_VALUE; // RQ6
            val_d  = table_q[idx];
         end else if (idx == 10'h000)
            // Entry zero stays locked even when the vendor key is present.
            err_d = `ERR_PROTECT; // RQ8
         else if (idx <= `IDX_PROT_MAX && !vendor_access_key)
            err_d = `ERR_ACCESS; // RQ14
         else begin
            kind_d = RESP_WRITE_ECHO; // RQ7
            val_d  = num_q[1];
            wr_en  = ans_d;
         end
      end else
         err_d = `ERR_UNSUP; // RQ9
   end

   always_ff @(posedge sys_clk) begin
      if (wr_en)
         table_q[idx] <= num_q[1]; // RQ7
   end

   // Hour timer: clear takes priority over the hour tick in the same cycle.
   always_ff @(posedge sys_clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         cyc_q   <= 40'h0;
         hours_q <= `ZERO32;
      end else if (clr_hours) begin
         cyc_q   <= 40'h0; // RQ1
         hours_q <= `ZERO32;
      end else if (cyc_q >= HOUR_CYCLES - 40'h1) begin
         cyc_q   <= 40'h0;
         hours_q <= hours_q + 32'h1;
      end else
         cyc_q <= cyc_q + 40'h1;
   end

   always_ff @(posedge sys_clk or negedge rst_s2_q) begin
      if (!rst_s2_q)
         bl_q <= `BL_RESET;
      else if (ans_d && kind_d == RESP_VALUE && cmd_len_q == 2'h1 && cmd0_q == `CH_B)
         bl_q <= 12'((num_q[0][6:0] * 19'(`BL_FULL) + 19'h00032) / 19'h00064); // RQ4
   end

   always_ff @(posedge sys_clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         resp_valid <= 1'b0;
         resp_kind  <= RESP_VALUE;
         resp_value <= `ZERO32;
         resp_index <= 10'h0;
         resp_error <= `ERR_NONE;
         resp_pct_x10 <= 17'h0;
      end else begin
         resp_valid <= ans_d; // RQ15
         if (ans_d) begin
            resp_kind  <= kind_d;
            resp_value <= (kind_d == RESP_BACKLIGHT) ? {20'h0, bl_q} : val_d; // RQ5
            resp_index <= idx;
            resp_error <= err_d;
            resp_pct_x10 <= 17'((29'(bl_q) * 29'(`PCT_MAX) + 29'h7FF) / 29'(`BL_FULL)); // RQ5
         end
      end
   end

   assign backlight_counts = bl_q;
endmodule

// [testbench/uart_service_command_parser_properties.sv]
`timescale 1ns/1ns
module svc_cmd_checker (
   input wire logic                    sys_clk,
   input wire logic                    rst_n,
   input wire logic                    rx_valid,
   input wire logic [7:0]              rx_data,
   input wire logic                    resp_valid,
   input wire svc_cmd_pkg::resp_kind_t resp_kind,
   input wire logic [31:0]             resp_value,
   input wire logic [16:0]             resp_pct_x10,
   input wire logic [3:0]              resp_error,
   input wire logic [11:0]             backlight_counts
);
   import svc_cmd_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic eol;
   logic open_q;
   assign eol = rx_data == 8'h0D || rx_data == 8'h0A;
   // Remembers that the line in progress holds at least one character.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) open_q <= 1'b0;
      else if (rx_valid) open_q <= !eol;
   end
   chk_answer_cause: assert property (resp_valid |-> $past(rx_valid) && $past(eol))
      else $error("answer without line end");
   chk_answer_given: assert property (rx_valid && eol && open_q |=> resp_valid)
      else $error("line not answered");
   chk_one_pulse: assert property (resp_valid |=> !resp_valid)
      else $error("answer longer than one cycle");
   chk_no_code8: assert property (resp_valid |-> resp_error != 4'h8)
      else $error("reserved code seen");
   chk_err_kind: assert property (resp_valid |-> (resp_kind == RESP_ERROR) == (resp_error != 4'h0))
      else $error("error code and kind disagree");
   chk_bl_report: assert property (resp_valid && resp_kind == RESP_BACKLIGHT |->
      resp_value == {20'h00000, backlight_counts} && resp_pct_x10 <= 17'h003E8)
      else $error("backlight report wrong");
   chk_bl_change: assert property ($changed(backlight_counts) |-> resp_valid && resp_kind == RESP_VALUE)
      else $error("backlight changed without command");
   chk_resp_hold: assert property (!resp_valid |-> $stable(resp_value) && $stable(resp_kind))
      else $error("answer fields moved");
endmodule
bind uart_service_command_parser svc_cmd_checker u_chk (.sys_clk, .rst_n, .rx_valid, .rx_data,
   .resp_valid, .resp_kind, .resp_value, .resp_pct_x10, .resp_error, .backlight_counts);

// [testbench/svc_host_model.sv]
`timescale 1ns/1ns
module svc_host_model (
   input  wire logic       sys_clk,
   input  wire logic       resp_valid,
   output logic            rx_valid,
   output logic [7:0]      rx_data
);
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'hA5;
   end
   // Sends one line ended by CR, then waits a few cycles for its answer.
   task automatic send_line(input string s, output logic got);
      int i;
      got = 1'b0;
      for (i = 0; i <= s.len(); i++) begin
         @(posedge sys_clk);
         #1;
         rx_valid = 1'b1;
         rx_data = (i == s.len()) ? 8'h0D : s[i];
      end
      for (i = 0; i < 4 && !got; i++) begin
         @(posedge sys_clk);
         #1;
         rx_valid = 1'b0;
         rx_data = ~rx_data;
         got = resp_valid;
      end
   endtask
endmodule

// [testbench/tb_uart_service_command_parser.sv]
`timescale 1ns/1ns
module tb_uart_service_command_parser;
   import svc_cmd_pkg::*;
   logic sys_clk = 0, rst_n = 0, back_door_en = 0, vendor_access_key = 0, rx_valid, resp_valid, got;
   logic [7:0] rx_data;
   logic [31:0] full_scale_lpm = 32'h00000000, resp_value;
   logic [9:0] resp_index;
   logic [16:0] resp_pct_x10;
   logic [3:0] resp_error;
   logic [11:0] backlight_counts;
   resp_kind_t resp_kind;
   int n_errors = 0, n_tests = 0, p, i, v, mem[int];
   string bad[] = '{"X", "C,X", "C,RR", "C,R,R", "B,1A", "E,1", "MR", "MR,1000", "MR,00001",
                    "MW,0,1", "MW,2,1", "MW,5,1234567"};
   int code[] = '{1, 6, 4, 2, 7, 2, 2, 3, 4, 5, 9, 4};
   always #4 sys_clk = ~sys_clk;
   uart_service_command_parser #(.HOUR_CYCLES(40'h0000000014)) u_uart_service_command_parser (
      .sys_clk, .rst_n, .rx_valid, .rx_data, .back_door_en, .vendor_access_key, .full_scale_lpm,
      .resp_valid, .resp_kind, .resp_value, .resp_index, .resp_pct_x10, .resp_error,
      .backlight_counts);
   svc_host_model u_svc_host_model (.sys_clk, .resp_valid, .rx_valid, .rx_data);
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // A negative value means the answer value is not compared.
   task cmd(input string s, input resp_kind_t k, input longint x, input int e);
      u_svc_host_model.send_line(s, got);
      check(got, 1);
      check(resp_kind, k);
      check(resp_error, e);
      if (x >= 0) check(resp_value, x[31:0]);
      $display("test done: %s", s);
   endtask
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #400000;
      n_errors++;
      report_and_stop;
   end
   initial begin
      void'($urandom(32'h9919));
      repeat (4) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      repeat (2) @(posedge sys_clk);
      cmd("C,C", RESP_CLEAR_ACK, -1, 0);
      cmd("C,R", RESP_VALUE, 0, 0);
      repeat (100) @(posedge sys_clk);
      cmd("C,R", RESP_VALUE, -1, 0);
      check(resp_value inside {[4:6]}, 1);
      full_scale_lpm = $urandom;
      cmd("E", RESP_VALUE, full_scale_lpm, 0);
      for (i = 0; i < 5; i++) begin
         p = i == 0 ? 0 : i == 1 ? 100 : $urandom_range(99, 1);
         cmd($sformatf("B,%0d", p), RESP_VALUE, p, 0);
         check(backlight_counts, (p * 4095 + 50) / 100);
         cmd("B", RESP_BACKLIGHT, (p * 4095 + 50) / 100, 0);
         check(resp_pct_x10 + 1 - p * 10 <= 2, 1);
      end
      cmd("B,101", RESP_ERROR, -1, 7);
      cmd("MR,5", RESP_ERROR, -1, 1);
      back_door_en = 1'b1;
      foreach (bad[j]) cmd(bad[j], RESP_ERROR, -1, code[j]);
      vendor_access_key = 1'b1;
      cmd("MW,0,1", RESP_ERROR, -1, 5);
      cmd("MW,2,77", RESP_WRITE_ECHO, 77, 0);
      mem[2] = 77;
      for (i = 0; i < 4; i++) begin
         p = i == 0 ? 999 : $urandom_range(999, 4);
         v = $urandom_range(999999, 0);
         mem[p] = v;
         cmd($sformatf("MW,%0d,%0d", p, v), RESP_WRITE_ECHO, v, 0);
         check(resp_index, p);
      end
      foreach (mem[k]) cmd($sformatf("MR,%0d", k), RESP_VALUE, mem[k], 0);
      u_svc_host_model.send_line("", got);
      check(got, 0);
      report_and_stop;
   end
endmodule
